// file: pkg/bmsf_pkg.sv
package bmsf_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int DEPTH = 2048;
  localparam int AW = 11;
  localparam int PW = 12;
  localparam int DW = 36;
  localparam logic [11:0] DEPTH_W = 12'h800;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_AE_OFS = 8'h0C;
  localparam logic [7:0] REG_AF_OFS = 8'h10;
  localparam logic [7:0] REG_SERIAL = 8'h14;

  // Control bits (write-only pulses)
  localparam int CTRL_FULL_RST = 0;
  localparam int CTRL_PART_RST = 1;
  localparam int CTRL_RETX = 2;

  // Config fields
  localparam int CFG_ET = 0;
  localparam int CFG_BM = 1;
  localparam int CFG_SIZE = 2;
  localparam int CFG_FS = 3;
  localparam int CFG_PARITY = 6;
  localparam int CFG_RTM = 7;
  localparam logic [7:0] CFG_RESET = 8'h01;

  // Offset select codes
  localparam logic [2:0] FS_SERIAL = 3'h5;
  localparam logic [2:0] FS_DEF_LAST = 3'h4;
  localparam logic [10:0] OFS_D0 = 11'h008;
  localparam logic [10:0] OFS_D1 = 11'h010;
  localparam logic [10:0] OFS_D2 = 11'h040;
  localparam logic [10:0] OFS_D3 = 11'h100;
  localparam logic [10:0] OFS_D4 = 11'h400;

  // Timing
  localparam logic [2:0] RETX_CYCLES = 3'h4;
  localparam logic [3:0] SER_LAST = 4'hA;

  typedef enum logic [1:0] {BMSF_W36, BMSF_W18, BMSF_W9} bmsf_width_t;
  typedef enum logic [1:0] {BMSF_PROG_AE, BMSF_PROG_AF, BMSF_PROG_DONE} bmsf_prog_t;
endpackage

// file: hw/bmsf_fifo.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Buffers 36-bit words from port A to port B in a 2048-deep memory.
// - Port B delivers data as 36-, 18- or 9-bit units.
// - Transfers happen only on a clock rising edge qualified by port enables.
// - Write and read may both happen on the same edge correctly.
// - Two mailboxes pass words between ports, masked to the port B width.
// - Each mailbox has an active-low flag set when new mail is stored.
// - Full reset zeroes both pointers and latches the offset programming method.
// - Partial reset zeroes pointers but keeps method and offsets.
// - Retransmit request with mode high rewinds read pointer after four cycles.
// - Standard mode needs a read to present the first word.
// - Fall-through mode presents the first word without a read.
// - Timing mode comes from the endian/timing select.
// - Standard mode flags show empty and full.
// - Fall-through mode flags show input ready and output ready.
// - Almost-empty and almost-full flags track programmable thresholds.
// - Flags pass through two synchronising stages before showing good news.
// - Offsets load in parallel over port A or serially bit by bit.
// - Offset select picks serial, parallel or defaults 8/16/64/256/1024.
// - With parity selected, port A bit 8 is skipped during parallel loading.
// - Narrow reads support big- and little-endian sub-word order.
// - Almost-empty low when stored words are at most the almost-empty offset.
// - Almost-full low when free locations are at most the almost-full offset.
// - Endian latched at full reset; afterwards the level selects timing mode.
// - Bus match low gives 36 bits; high gives 18 or 9 by size bit.
module bmsf_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic porta_write_en,
  input wire logic porta_mbox_write_en,
  input wire logic porta_mbox_read_en,
  input wire logic [35:0] porta_data,
  output logic [35:0] porta_mbox_data,
  input wire logic portb_read_en,
  input wire logic portb_mbox_read_en,
  input wire logic portb_mbox_write_en,
  input wire logic [35:0] portb_mbox_wdata,
  output logic [35:0] portb_data,
  output logic [35:0] portb_mbox_data,
  output logic empty_or_output_ready_flag,
  output logic full_or_input_ready_flag,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic mailbox1_new_mail_flag_n,
  output logic mailbox2_new_mail_flag_n
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [35:0] mem [0:bmsf_pkg::DEPTH-1];
  logic [7:0] cfg;
  logic [11:0] wptr;
  logic [11:0] rptr;
  logic [11:0] count;
  logic [11:0] free_cnt;
  logic [35:0] cur;
  logic [35:0] head;
  logic [35:0] wmask;
  logic [35:0] mbox1;
  logic [35:0] mbox2;
  logic [1:0] sub;
  logic [1:0] last;
  logic hold;
  logic cap_pend;
  logic big_endian;
  logic parity_sel;
  logic [2:0] ofs_sel;
  logic [10:0] ae_ofs;
  logic [10:0] af_ofs;
  logic [10:0] par_ofs;
  logic [3:0] ser_cnt;
  bmsf_pkg::bmsf_prog_t prog;
  logic prog_done;
  logic [2:0] rt_cnt;
  logic rt_fire;
  logic first_word_passthrough_mode;
  logic mem_empty;
  logic mem_full;
  logic wr_fifo;
  logic acc;
  logic wr;
  logic mapped;
  logic full_rst_cmd;
  logic part_rst_cmd;
  logic clr;
  logic ser_wr;
  logic [3:0] ok_raw;
  logic [3:0] ok_s1;
  logic [3:0] ok_s2;
  logic [31:0] rd_mux;
  bmsf_pkg::bmsf_width_t wsel;

  function automatic logic [35:0] pick_sub(input logic [35:0] w, input logic [1:0] idx,
                                           input bmsf_pkg::bmsf_width_t wd, input logic be,
                                           input logic [1:0] lst);
    logic [1:0] k;
    k = be ? 2'(lst - idx) : idx;
    case (wd)
      bmsf_pkg::BMSF_W18: pick_sub = {18'h0, w[k[0]*18 +: 18]};
      bmsf_pkg::BMSF_W9: pick_sub = {27'h0, w[k*9 +: 9]};
      default: pick_sub = w;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == bmsf_pkg::REG_CTRL) || (paddr == bmsf_pkg::REG_CFG) ||
                  (paddr == bmsf_pkg::REG_STATUS) || (paddr == bmsf_pkg::REG_AE_OFS) ||
                  (paddr == bmsf_pkg::REG_AF_OFS) || (paddr == bmsf_pkg::REG_SERIAL);
  assign pslverr = acc & ~mapped;
  assign full_rst_cmd = wr && paddr == bmsf_pkg::REG_CTRL && pwdata[bmsf_pkg::CTRL_FULL_RST];
  assign part_rst_cmd = wr && paddr == bmsf_pkg::REG_CTRL && pwdata[bmsf_pkg::CTRL_PART_RST];
  assign ser_wr = wr && paddr == bmsf_pkg::REG_SERIAL;
  assign clr = full_rst_cmd | part_rst_cmd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= bmsf_pkg::CFG_RESET;
    end else if (wr && paddr == bmsf_pkg::REG_CFG) begin
      cfg <= pwdata[7:0];
    end
  end

  always_comb begin
    case (paddr)
      bmsf_pkg::REG_CFG: rd_mux = {24'h0, cfg};
      bmsf_pkg::REG_STATUS: rd_mux = {4'h0, count, 7'h0, big_endian, first_word_passthrough_mode, prog_done,
                                      mailbox2_new_mail_flag_n, mailbox1_new_mail_flag_n,
                                      almost_full_flag_n, almost_empty_flag_n,
                                      full_or_input_ready_flag, empty_or_output_ready_flag};
      bmsf_pkg::REG_AE_OFS: rd_mux = {21'h0, ae_ofs};
      bmsf_pkg::REG_AF_OFS: rd_mux = {21'h0, af_ofs};
      default: rd_mux = 32'h0;
    endcase
  end

  // Captured in the setup phase so the access phase can complete at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------
  assign first_word_passthrough_mode = ~cfg[bmsf_pkg::CFG_ET];
  always_comb begin
    if (!cfg[bmsf_pkg::CFG_BM]) begin
      wsel = bmsf_pkg::BMSF_W36;
    end else if (cfg[bmsf_pkg::CFG_SIZE]) begin
      wsel = bmsf_pkg::BMSF_W9;
    end else begin
      wsel = bmsf_pkg::BMSF_W18;
    end
  end
  assign last = (wsel == bmsf_pkg::BMSF_W36) ? 2'h0 :
                (wsel == bmsf_pkg::BMSF_W18) ? 2'h1 : 2'h3;
  assign wmask = (wsel == bmsf_pkg::BMSF_W36) ? 36'hFFFFFFFFF :
                 (wsel == bmsf_pkg::BMSF_W18) ? 36'h00003FFFF : 36'h0000001FF;

  // Straps are caught by a clock edge after release, never by the async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_pend <= 1'b1;
      big_endian <= 1'b0;
      parity_sel <= 1'b0;
      ofs_sel <= 3'h0;
    end else begin
      cap_pend <= 1'b0;
      if (cap_pend || full_rst_cmd) begin
        big_endian <= cfg[bmsf_pkg::CFG_ET];
        parity_sel <= cfg[bmsf_pkg::CFG_PARITY];
        ofs_sel <= cfg[bmsf_pkg::CFG_FS +: 3];
      end
    end
  end

  // ---------------------------------------------------------------
  // Offset programming
  // ---------------------------------------------------------------
  assign prog_done = (prog == bmsf_pkg::BMSF_PROG_DONE);
  assign par_ofs = parity_sel ? {porta_data[11:9], porta_data[7:0]} : porta_data[10:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog <= bmsf_pkg::BMSF_PROG_AE;
      ae_ofs <= 11'h0;
      af_ofs <= 11'h0;
      ser_cnt <= 4'h0;
    end else if (cap_pend || full_rst_cmd) begin
      ser_cnt <= 4'h0;
      prog <= bmsf_pkg::BMSF_PROG_DONE;
      case (cfg[bmsf_pkg::CFG_FS +: 3])
        3'h0: begin ae_ofs <= bmsf_pkg::OFS_D0; af_ofs <= bmsf_pkg::OFS_D0; end
        3'h1: begin ae_ofs <= bmsf_pkg::OFS_D1; af_ofs <= bmsf_pkg::OFS_D1; end
        3'h2: begin ae_ofs <= bmsf_pkg::OFS_D2; af_ofs <= bmsf_pkg::OFS_D2; end
        3'h3: begin ae_ofs <= bmsf_pkg::OFS_D3; af_ofs <= bmsf_pkg::OFS_D3; end
        3'h4: begin ae_ofs <= bmsf_pkg::OFS_D4; af_ofs <= bmsf_pkg::OFS_D4; end
        default: prog <= bmsf_pkg::BMSF_PROG_AE;
      endcase
    end else if (!prog_done && ofs_sel == bmsf_pkg::FS_SERIAL) begin
      if (ser_wr) begin
        ser_cnt <= (ser_cnt == bmsf_pkg::SER_LAST) ? 4'h0 : ser_cnt + 4'h1;
        if (prog == bmsf_pkg::BMSF_PROG_AE) begin
          ae_ofs <= {ae_ofs[9:0], pwdata[0]};
        end else begin
          af_ofs <= {af_ofs[9:0], pwdata[0]};
        end
        if (ser_cnt == bmsf_pkg::SER_LAST) begin
          prog <= (prog == bmsf_pkg::BMSF_PROG_AE) ? bmsf_pkg::BMSF_PROG_AF
                                                   : bmsf_pkg::BMSF_PROG_DONE;
        end
      end
    end else if (!prog_done && ofs_sel > bmsf_pkg::FS_SERIAL && porta_write_en) begin
      case (prog)
        bmsf_pkg::BMSF_PROG_AE: begin
          ae_ofs <= par_ofs;
          prog <= bmsf_pkg::BMSF_PROG_AF;
        end
        bmsf_pkg::BMSF_PROG_AF: begin
          af_ofs <= par_ofs;
          prog <= bmsf_pkg::BMSF_PROG_DONE;
        end
        default: prog <= bmsf_pkg::BMSF_PROG_DONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Write side
  // ---------------------------------------------------------------
  assign count = wptr - rptr;
  assign free_cnt = bmsf_pkg::DEPTH_W - count;
  assign mem_empty = (count == 12'h000);
  assign mem_full = (count == bmsf_pkg::DEPTH_W);
  assign wr_fifo = porta_write_en & prog_done & ~mem_full;
  assign head = mem[rptr[bmsf_pkg::AW-1:0]];

  always_ff @(posedge pclk) begin
    if (wr_fifo) begin
      mem[wptr[bmsf_pkg::AW-1:0]] <= porta_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= 12'h000;
    end else if (clr) begin
      wptr <= 12'h000;
    end else if (wr_fifo) begin
      wptr <= wptr + 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // Retransmit
  // ---------------------------------------------------------------
  assign rt_fire = (rt_cnt == 3'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_cnt <= 3'h0;
    end else if (clr) begin
      rt_cnt <= 3'h0;
    end else if (wr && paddr == bmsf_pkg::REG_CTRL && pwdata[bmsf_pkg::CTRL_RETX] &&
                 cfg[bmsf_pkg::CFG_RTM]) begin
      rt_cnt <= bmsf_pkg::RETX_CYCLES;
    end else if (rt_cnt != 3'h0) begin
      rt_cnt <= rt_cnt - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr <= 12'h000;
      sub <= 2'h0;
      hold <= 1'b0;
      cur <= 36'h0;
      portb_data <= 36'h0;
    end else if (clr || rt_fire) begin
      rptr <= 12'h000;
      sub <= 2'h0;
      hold <= 1'b0;
    end else if (first_word_passthrough_mode) begin
      if (hold && portb_read_en && sub != last) begin
        sub <= sub + 2'h1;
        portb_data <= pick_sub(cur, sub + 2'h1, wsel, big_endian, last);
      end else if ((!hold || portb_read_en) && !mem_empty) begin
        rptr <= rptr + 12'h001;
        cur <= head;
        portb_data <= pick_sub(head, 2'h0, wsel, big_endian, last);
        sub <= 2'h0;
        hold <= 1'b1;
      end else if (hold && portb_read_en) begin
        hold <= 1'b0;
      end
    end else if (portb_read_en) begin
      if (hold) begin
        portb_data <= pick_sub(cur, sub, wsel, big_endian, last);
        hold <= (sub != last);
        sub <= sub + 2'h1;
      end else if (!mem_empty) begin
        rptr <= rptr + 12'h001;
        cur <= head;
        portb_data <= pick_sub(head, 2'h0, wsel, big_endian, last);
        hold <= (last != 2'h0);
        sub <= 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  // Bad news shows at once; good news waits two stages
  assign ok_raw[0] = first_word_passthrough_mode ? hold : (hold | ~mem_empty);
  assign ok_raw[1] = ~mem_full & prog_done;
  assign ok_raw[2] = ({1'b0, ae_ofs} < count);
  assign ok_raw[3] = ({1'b0, af_ofs} < free_cnt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_s1 <= 4'h0;
      ok_s2 <= 4'h0;
    end else begin
      ok_s1 <= ok_raw;
      ok_s2 <= ok_s1;
    end
  end

  assign empty_or_output_ready_flag = ok_s2[0] & ok_raw[0];
  assign full_or_input_ready_flag = ok_s2[1] & ok_raw[1];
  assign almost_empty_flag_n = ok_s2[2] & ok_raw[2];
  assign almost_full_flag_n = ok_s2[3] & ok_raw[3];

  // ---------------------------------------------------------------
  // Mailboxes
  // ---------------------------------------------------------------
  // A new word beats a same-cycle read, so that read never loses the new mail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbox1 <= 36'h0;
      mailbox1_new_mail_flag_n <= 1'b1;
      portb_mbox_data <= 36'h0;
    end else begin
      if (portb_mbox_read_en) begin
        portb_mbox_data <= mbox1;
      end
      if (porta_mbox_write_en) begin
        mbox1 <= porta_data & wmask;
        mailbox1_new_mail_flag_n <= 1'b0;
      end else if (portb_mbox_read_en || full_rst_cmd) begin
        mailbox1_new_mail_flag_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbox2 <= 36'h0;
      mailbox2_new_mail_flag_n <= 1'b1;
      porta_mbox_data <= 36'h0;
    end else begin
      if (porta_mbox_read_en) begin
        porta_mbox_data <= mbox2;
      end
      if (portb_mbox_write_en) begin
        mbox2 <= portb_mbox_wdata & wmask;
        mailbox2_new_mail_flag_n <= 1'b0;
      end else if (porta_mbox_read_en || full_rst_cmd) begin
        mailbox2_new_mail_flag_n <= 1'b1;
      end
    end
  end
endmodule

// file: sim/bmsf_fifo_assertions.sv
`timescale 1ns/1ns
module bmsf_fifo_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic porta_mbox_write_en,
  input wire logic porta_mbox_read_en,
  input wire logic portb_mbox_read_en,
  input wire logic portb_mbox_write_en,
  input wire logic empty_or_output_ready_flag,
  input wire logic almost_empty_flag_n,
  input wire logic mailbox1_new_mail_flag_n,
  input wire logic mailbox2_new_mail_flag_n
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence full_rst_s;
    psel && penable && pwrite && paddr == 8'h00 && pwdata[0]
      && !porta_mbox_write_en && !portb_mbox_write_en;
  endsequence
  sequence part_rst_s;
    psel && penable && pwrite && paddr == 8'h00 && pwdata[1] && !pwdata[0];
  endsequence
  // Two low cycles: good news may not show before two stages
  sequence flushed_s;
    (!empty_or_output_ready_flag && !almost_empty_flag_n) [*2];
  endsequence
  unmapped_err_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("no error on unmapped access");
  idle_err_a: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  read_hold_a: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
  mb1_set_a: assert property (porta_mbox_write_en |=> !mailbox1_new_mail_flag_n)
    else $error("mailbox one flag not set");
  mb2_set_a: assert property (portb_mbox_write_en |=> !mailbox2_new_mail_flag_n)
    else $error("mailbox two flag not set");
  mb1_clear_a: assert property (portb_mbox_read_en && !porta_mbox_write_en |=> mailbox1_new_mail_flag_n)
    else $error("mailbox one flag not cleared");
  mb2_clear_a: assert property (porta_mbox_read_en && !portb_mbox_write_en |=> mailbox2_new_mail_flag_n)
    else $error("mailbox two flag not cleared");
  full_rst_a: assert property (full_rst_s |=> mailbox1_new_mail_flag_n && mailbox2_new_mail_flag_n ##0 flushed_s)
    else $error("full reset did not clear");
  part_rst_a: assert property (part_rst_s |=> flushed_s)
    else $error("partial reset did not flush");
endmodule

// file: sim/bmsf_reader.sv
`timescale 1ns/1ns
module bmsf_reader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic slow,
  input wire logic avail,
  output logic read_en
);
  // ---------------------------------------------------------------
  // Port B reader
  // ---------------------------------------------------------------
  // Reads only after seeing data flagged, so a lagging flag never hides a take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_en <= 1'b0;
    end else begin
      read_en <= go && avail && (!slow || 1'($urandom_range(1)));
    end
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ns
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, portb_read_en, be = 1;
  logic porta_write_en = 0, porta_mbox_write_en = 0, porta_mbox_read_en = 0;
  logic portb_mbox_read_en = 0, portb_mbox_write_en = 0;
  logic [35:0] porta_data = 0, portb_mbox_wdata = 0, porta_mbox_data, portb_data, portb_mbox_data;
  logic [35:0] hist [8], w;
  logic eo, fi, aen, afn, mb1n, mb2n;
  logic [10:0] ofs [5] = '{bmsf_pkg::OFS_D0, bmsf_pkg::OFS_D1, bmsf_pkg::OFS_D2,
    bmsf_pkg::OFS_D3, bmsf_pkg::OFS_D4};
  logic [35:0] q [$];
  int mismatches = 0, cmp_count = 0, wmode = 0;
  bmsf_fifo dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .porta_write_en(porta_write_en), .porta_mbox_write_en(porta_mbox_write_en),
    .porta_mbox_read_en(porta_mbox_read_en), .porta_data(porta_data),
    .porta_mbox_data(porta_mbox_data), .portb_read_en(portb_read_en),
    .portb_mbox_read_en(portb_mbox_read_en), .portb_mbox_write_en(portb_mbox_write_en),
    .portb_mbox_wdata(portb_mbox_wdata), .portb_data(portb_data),
    .portb_mbox_data(portb_mbox_data), .empty_or_output_ready_flag(eo),
    .full_or_input_ready_flag(fi), .almost_empty_flag_n(aen), .almost_full_flag_n(afn),
    .mailbox1_new_mail_flag_n(mb1n), .mailbox2_new_mail_flag_n(mb2n));
  bmsf_reader rd (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow), .avail(eo),
    .read_en(portb_read_en));
  always #5 pclk = ~pclk;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= wr; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wr(input int n);
    int k, u, c;
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      w = {4'($urandom), 32'($urandom)};
      hist[i] = w;
      c = (wmode == 0) ? 1 : (wmode == 1) ? 2 : 4;
      for (k = 0; k < c; k++) begin
        u = be ? c - 1 - k : k;
        if (wmode == 0) q.push_back(w);
        else if (wmode == 1) q.push_back({18'h0, w[u*18 +: 18]});
        else q.push_back({27'h0, w[u*9 +: 9]});
      end
      porta_write_en <= 1; porta_data <= w;
      @(posedge pclk);
    end
    porta_write_en <= 0;
  endtask
  task automatic drain();
    int t;
    t = 0;
    go <= 1;
    while (q.size() != 0 && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    if (q.size() != 0) begin
      mismatches++;
      $display("wrong value at %0t: data missing", $time);
    end
    go <= 0;
    settle(4);
  endtask
  // Oldest note is compared with each unit the reader takes
  always @(posedge pclk) begin
    if (presetn && portb_read_en && eo) begin
      #1;
      if (q.size() == 0) begin
        mismatches++;
        $display("wrong value at %0t: unexpected read", $time);
      end else check(portb_data, q.pop_front());
    end
  end
  initial begin
    #300000;
    mismatches++;
    conclude();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(38451));
    settle(2);
    check({34'h0, mb1n, mb2n}, 36'h3);
    check({35'h0, eo}, 36'h0);
    @(posedge pclk);
    presetn <= 1;
    wr(1);
    settle(6);
    check(portb_data, 36'h0);
    check({35'h0, eo}, 36'h1);
    wr(8);
    settle(5);
    check({34'h0, aen, afn}, 36'h3);
    slow <= 1;
    drain();
    check({35'h0, aen}, 36'h0);
    // Endian is latched at full reset, then b0 returns to standard timing
    for (int i = 0; i < 4; i++) begin
      wmode = 1 + i / 2;
      be = i[0];
      apb(bmsf_pkg::REG_CFG, 1, 32'h2 | (wmode == 2 ? 32'h4 : 32'h0) | 32'(be));
      apb(bmsf_pkg::REG_CTRL, 1, 32'h1);
      apb(bmsf_pkg::REG_CFG, 1, 32'h3 | (wmode == 2 ? 32'h4 : 32'h0));
      slow <= i[0];
      go <= 1;
      wr(3);
      drain();
    end
    @(posedge pclk);
    porta_mbox_write_en <= 1; porta_data <= 36'hFFFFFFFFF;
    @(posedge pclk);
    porta_mbox_write_en <= 0;
    settle(1);
    check({35'h0, mb1n}, 36'h0);
    @(posedge pclk);
    portb_mbox_read_en <= 1;
    @(posedge pclk);
    portb_mbox_read_en <= 0;
    settle(1);
    check(portb_mbox_data, 36'h1FF);
    check({35'h0, mb1n}, 36'h1);
    @(posedge pclk);
    w = {4'($urandom), 32'($urandom)};
    portb_mbox_write_en <= 1; portb_mbox_wdata <= w;
    @(posedge pclk);
    portb_mbox_write_en <= 0;
    porta_mbox_read_en <= 1;
    @(posedge pclk);
    porta_mbox_read_en <= 0;
    settle(1);
    check(porta_mbox_data, w & 36'h1FF);
    check({35'h0, mb2n}, 36'h1);
    wmode = 0;
    apb(bmsf_pkg::REG_CFG, 1, 32'h81);
    apb(bmsf_pkg::REG_CTRL, 1, 32'h1);
    wr(3);
    drain();
    apb(bmsf_pkg::REG_CTRL, 1, 32'h4);
    settle(8);
    for (int i = 0; i < 3; i++) q.push_back(hist[i]);
    drain();
    apb(bmsf_pkg::REG_CFG, 1, 32'h80);
    wr(1);
    q.delete();
    settle(6);
    check(portb_data, hist[0]);
    check({35'h0, eo}, 36'h1);
    apb(bmsf_pkg::REG_CTRL, 1, 32'h2);
    settle(1);
    check({35'h0, eo}, 36'h0);
    for (int f = 0; f < 5; f++) begin
      apb(bmsf_pkg::REG_CFG, 1, (32'(f) << 3) | 32'h1);
      apb(bmsf_pkg::REG_CTRL, 1, 32'h1);
      apb(bmsf_pkg::REG_AE_OFS, 0, 32'h0);
      check({4'h0, r}, {25'h0, ofs[f]});
      apb(bmsf_pkg::REG_AF_OFS, 0, 32'h0);
      check({4'h0, r}, {25'h0, ofs[f]});
    end
    apb(bmsf_pkg::REG_CTRL, 1, 32'h2);
    apb(bmsf_pkg::REG_AE_OFS, 0, 32'h0);
    check({4'h0, r}, {25'h0, ofs[4]});
    apb(8'h20, 0, 32'h0);
    check({3'h0, e, r}, 36'h100000000);
    // Parallel load with parity on drops bit 8; no room is shown until both offsets land
    apb(bmsf_pkg::REG_CFG, 1, 32'h71);
    apb(bmsf_pkg::REG_CTRL, 1, 32'h1);
    settle(1);
    check({35'h0, fi}, 36'h0);
    @(posedge pclk);
    porta_write_en <= 1; porta_data <= 36'h3FF;
    @(posedge pclk);
    porta_data <= 36'h123;
    @(posedge pclk);
    porta_write_en <= 0;
    apb(bmsf_pkg::REG_AE_OFS, 0, 32'h0);
    check({4'h0, r}, 36'h1FF);
    apb(bmsf_pkg::REG_AF_OFS, 0, 32'h0);
    check({4'h0, r}, 36'h023);
    settle(3);
    check({35'h0, fi}, 36'h1);
    // Serial load: almost-empty offset first, most significant bit first
    apb(bmsf_pkg::REG_CFG, 1, 32'h29);
    apb(bmsf_pkg::REG_CTRL, 1, 32'h1);
    w = 36'($urandom_range(32'h3FFFFF));
    for (int i = 21; i >= 0; i--) apb(bmsf_pkg::REG_SERIAL, 1, 32'(w[i]));
    apb(bmsf_pkg::REG_AE_OFS, 0, 32'h0);
    check({4'h0, r}, {25'h0, w[21:11]});
    apb(bmsf_pkg::REG_AF_OFS, 0, 32'h0);
    check({4'h0, r}, {25'h0, w[10:0]});
    conclude();
  end
endmodule
bind bmsf_fifo bmsf_fifo_assertions chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .porta_mbox_write_en(porta_mbox_write_en),
  .porta_mbox_read_en(porta_mbox_read_en), .portb_mbox_read_en(portb_mbox_read_en),
  .portb_mbox_write_en(portb_mbox_write_en),
  .empty_or_output_ready_flag(empty_or_output_ready_flag),
  .almost_empty_flag_n(almost_empty_flag_n), .mailbox1_new_mail_flag_n(mailbox1_new_mail_flag_n),
  .mailbox2_new_mail_flag_n(mailbox2_new_mail_flag_n));
